/* File: verilog/sccm_pkg.sv */
// Purpose: shared constants and types of the serial configuration command handler
// Assumes: 100 MHz module clock
// Notes:   parameter identifiers are internal codes, not wire codes
package sccm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ        = 100_000_000;
  localparam int     TICK_TIME_MS  = 100;
  localparam int     TICK_CYC      = int'(CLK_HZ / 1000 * TICK_TIME_MS);
  localparam int     BIN_TMO_MS    = 500;
  localparam logic [15:0] BIN_TMO_TICKS = 16'(BIN_TMO_MS / TICK_TIME_MS);
  localparam int     ESC_WIN_MS    = 1000;
  localparam logic [15:0] ESC_WIN_TICKS = 16'(ESC_WIN_MS / TICK_TIME_MS);
  localparam logic [1:0]  BOOT_WAIT     = 2'h3;

  // ----------------------------------------------------------------
  // parameter defaults
  // ----------------------------------------------------------------
  localparam logic [15:0] DEF_DEST   = 16'h0000;
  localparam logic [15:0] DEF_GUARD  = 16'h000a;
  localparam logic [15:0] DEF_CTMO   = 16'h00c8;
  localparam logic [7:0]  DEF_ESC    = 8'h2b;
  localparam logic [7:0]  DEF_BIN_EN = 8'h00;
  localparam logic [7:0]  RATE_9600  = 8'h03;
  localparam logic [7:0]  BIN_EN_ON  = 8'h01;

  // ----------------------------------------------------------------
  // binary command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] BC_DEST  = 7'h00;
  localparam logic [6:0] BC_GBT   = 7'h04;
  localparam logic [6:0] BC_GAT   = 7'h05;
  localparam logic [6:0] BC_CTMO  = 7'h06;
  localparam logic [6:0] BC_SAVE  = 7'h08;
  localparam logic [6:0] BC_EXIT  = 7'h09;
  localparam logic [6:0] BC_ESC   = 7'h13;
  localparam logic [6:0] BC_BINEN = 7'h14;
  localparam logic [6:0] BC_RATE  = 7'h15;
  localparam int         BC_QUERY_BIT = 7;

  // ----------------------------------------------------------------
  // text command letter pairs and characters
  // ----------------------------------------------------------------
  localparam logic [15:0] TX_DEST  = 16'h4454;
  localparam logic [15:0] TX_GBT   = 16'h4254;
  localparam logic [15:0] TX_GAT   = 16'h4154;
  localparam logic [15:0] TX_CTMO  = 16'h4354;
  localparam logic [15:0] TX_ESC   = 16'h4343;
  localparam logic [15:0] TX_BINEN = 16'h5254;
  localparam logic [15:0] TX_RATE  = 16'h4244;
  localparam logic [15:0] TX_SAVE  = 16'h5752;
  localparam logic [15:0] TX_EXIT  = 16'h434e;
  localparam logic [7:0]  CH_A  = 8'h41;
  localparam logic [7:0]  CH_T  = 8'h54;
  localparam logic [7:0]  CH_CR = 8'h0d;
  localparam logic [63:0] MSG_OK  = 64'h4f4b0d0000000000;
  localparam logic [3:0]  MSG_OK_N  = 4'h3;
  localparam logic [63:0] MSG_ERR = 64'h4552524f520d0000;
  localparam logic [3:0]  MSG_ERR_N = 4'h6;
  localparam logic [3:0]  MSG_VAL_N = 4'h5;
  localparam logic [3:0]  MSG_BIN_N = 4'h2;

  typedef enum logic [3:0] {
    ID_DEST, ID_GBT, ID_GAT, ID_CTMO, ID_ESC, ID_BINEN, ID_RATE, ID_SAVE, ID_EXIT, ID_BAD
  } sccm_id_e;

  typedef enum logic [1:0] {B_IDLE, B_LO, B_HI, B_RUN} sccm_bin_e;

  typedef struct packed {
    logic [15:0] dest;
    logic [15:0] gbt;
    logic [15:0] gat;
    logic [15:0] ctmo;
    logic [7:0]  esc;
    logic [7:0]  bin_en;
    logic [7:0]  rate;
  } sccm_prm_s;

  localparam sccm_prm_s PRM_DEFAULT = '{DEF_DEST, DEF_GUARD, DEF_GUARD, DEF_CTMO,
                                        DEF_ESC, DEF_BIN_EN, RATE_9600};
endpackage

/* File: verilog/sccm_top.sv */
// Purpose: serial configuration command handler, text and binary command paths
// Assumes: rx bytes arrive from a uart receiver on this clock at end of stop bit
// Notes:   guard and timeout timers run at 100 ms tick granularity
//
// Function
// - in command mode received characters are commands; parameters change only there or through binary commands
// - changes hit working set; reset restores saved set, losing changes unless save command ran
// - text entry: silence, three escape chars within one second, silence
// - configuration strap low at power-up starts the device in command mode
// - text command with empty parameter reads the current value
// - each text command answers OK on success (a read answers its value and CR), ERROR on failure
// - no valid text command within timeout leaves command mode
// - binary commands recognised only while select pin is high
// - select pin sampled once per byte at end of its stop bit
// - binary command inserted among payload executes in arrival order
// - pending binary command waits for a gap in radio receive data
// - clear-to-send frames binary response bytes
// - binary command runs when parameters complete; 0.5 s timeout aborts it
// - code with top bit set is a query returning the current value
// - binary recognition only when binary enable equals one
// - destination address code 00, save code 08, single byte
// - interface rate defaults to 9600 after reset
// - guard times in 100 ms units, default ten units
// - escape character programmable, default plus sign
// - command timeout in 100 ms units, default 200 units
// - exit command leaves command mode at once, binary code 09
`timescale 1ns/10ps
module sccm_top
  import sccm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        cmd_select_in,
  input  wire logic        config_strap_n_in,
  input  wire logic        rf_rx_busy_in,
  input  wire logic        tx_ready_in,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  output logic             cts_out,
  output logic             payload_valid_out,
  output logic [7:0]       payload_data_out,
  output logic             command_mode_out,
  output logic [15:0]      destination_address_out,
  output logic [7:0]       binary_enable_cfg_out,
  output logic [7:0]       interface_rate_out,
  output logic [7:0]       escape_character_out
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 2 || TICK_CYCLES > 24'hffffff) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sel_s1;
    logic        sel_s2;
    logic        strap_s1;
    logic        strap_s2;
    logic [1:0]  boot;
    logic [23:0] tick_cnt;
    sccm_prm_s   prm;
    logic        cmd_mode;
    logic [15:0] silence;
    logic [1:0]  esc_cnt;
    logic [15:0] esc_time;
    logic [15:0] ctmo_cnt;
    logic [2:0]  t_cnt;
    logic [15:0] t_pair;
    logic [15:0] t_val;
    logic        t_has_val;
    logic        t_err;
    sccm_bin_e   b_state;
    logic [7:0]  b_code;
    logic [15:0] b_val;
    logic [15:0] b_time;
    logic [63:0] resp_buf;
    logic [3:0]  resp_n;
    logic        resp_bin;
    logic        pay_valid;
    logic [7:0]  pay_data;
    logic        save;
  } sccm_state_s;

  sccm_state_s state_reg;
  sccm_state_s state_next;
  sccm_state_s state_rst;
  // saved set survives reset; power-up contents are the defaults
  sccm_prm_s   nv_reg = PRM_DEFAULT;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic sccm_id_e txt_id(input logic [15:0] pair);
    unique case (pair)
      TX_DEST:  txt_id = ID_DEST;
      TX_GBT:   txt_id = ID_GBT;
      TX_GAT:   txt_id = ID_GAT;
      TX_CTMO:  txt_id = ID_CTMO;
      TX_ESC:   txt_id = ID_ESC;
      TX_BINEN: txt_id = ID_BINEN;
      TX_RATE:  txt_id = ID_RATE;
      TX_SAVE:  txt_id = ID_SAVE;
      TX_EXIT:  txt_id = ID_EXIT;
      default:  txt_id = ID_BAD;
    endcase
  endfunction

  function automatic sccm_id_e bin_id(input logic [6:0] code);
    unique case (code)
      BC_DEST:  bin_id = ID_DEST;
      BC_GBT:   bin_id = ID_GBT;
      BC_GAT:   bin_id = ID_GAT;
      BC_CTMO:  bin_id = ID_CTMO;
      BC_ESC:   bin_id = ID_ESC;
      BC_BINEN: bin_id = ID_BINEN;
      BC_RATE:  bin_id = ID_RATE;
      BC_SAVE:  bin_id = ID_SAVE;
      BC_EXIT:  bin_id = ID_EXIT;
      default:  bin_id = ID_BAD;
    endcase
  endfunction

  function automatic logic [15:0] prm_read(input sccm_prm_s p, input sccm_id_e id);
    unique case (id)
      ID_DEST:  prm_read = p.dest;
      ID_GBT:   prm_read = p.gbt;
      ID_GAT:   prm_read = p.gat;
      ID_CTMO:  prm_read = p.ctmo;
      ID_ESC:   prm_read = {8'h00, p.esc};
      ID_BINEN: prm_read = {8'h00, p.bin_en};
      ID_RATE:  prm_read = {8'h00, p.rate};
      default:  prm_read = 16'h0000;
    endcase
  endfunction

  // working set only; the saved set moves on the save command
  function automatic sccm_prm_s prm_write(input sccm_prm_s p, input sccm_id_e id,
                                          input logic [15:0] v);
    prm_write = p;
    unique case (id)
      ID_DEST:  prm_write.dest   = v;
      ID_GBT:   prm_write.gbt    = v;
      ID_GAT:   prm_write.gat    = v;
      ID_CTMO:  prm_write.ctmo   = v;
      ID_ESC:   prm_write.esc    = v[7:0];
      ID_BINEN: prm_write.bin_en = v[7:0];
      ID_RATE:  prm_write.rate   = v[7:0];
      default:  prm_write = p;
    endcase
  endfunction

  function automatic logic [7:0] hex_asc(input logic [3:0] n);
    hex_asc = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [4:0] asc_hex(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      asc_hex = {1'b1, 4'(c - 8'h30)};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      asc_hex = {1'b1, 4'(c - 8'h37)};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      asc_hex = {1'b1, 4'(c - 8'h57)};
    end else begin
      asc_hex = 5'h00;
    end
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        tick;
    logic        bin_byte;
    logic [4:0]  hx;
    sccm_id_e    id;
    logic [15:0] rv;
    id = ID_BAD;
    rv = 16'h0000;
    state_rst = '0;
    state_rst.sel_s1   = 1'b0;
    state_rst.strap_s1 = 1'b1;
    state_rst.strap_s2 = 1'b1;
    state_rst.prm      = nv_reg;
    state_rst.b_state  = B_IDLE;
    state_next = state_reg;
    state_next.sel_s1   = cmd_select_in;
    state_next.sel_s2   = state_reg.sel_s1;
    state_next.strap_s1 = config_strap_n_in;
    state_next.strap_s2 = state_reg.strap_s1;
    state_next.pay_valid = 1'b0;
    state_next.save      = 1'b0;
    tick = (state_reg.tick_cnt == 24'(TICK_CYCLES - 1));
    state_next.tick_cnt = tick ? 24'h000000 : state_reg.tick_cnt + 24'h000001;
    // strap sampled once the synchroniser has settled after reset
    if (state_reg.boot != BOOT_WAIT) begin
      state_next.boot = state_reg.boot + 2'h1;
      if (state_reg.boot == BOOT_WAIT - 2'h1 && !state_reg.strap_s2) begin
        state_next.cmd_mode = 1'b1;
      end
    end
    // 100 ms timers
    if (tick) begin
      if (state_reg.silence != 16'hffff) state_next.silence = state_reg.silence + 16'h0001;
      if (state_reg.esc_time != 16'hffff) state_next.esc_time = state_reg.esc_time + 16'h0001;
      state_next.ctmo_cnt = state_reg.ctmo_cnt + 16'h0001;
      if (state_reg.b_state == B_LO || state_reg.b_state == B_HI) begin
        state_next.b_time = state_reg.b_time + 16'h0001;
        if (state_reg.b_time + 16'h0001 >= BIN_TMO_TICKS) begin
          state_next.b_state = B_IDLE;
        end
      end
      if (state_reg.esc_cnt == 2'h3 && state_reg.silence + 16'h0001 >= state_reg.prm.gat) begin
        state_next.cmd_mode = 1'b1;
        state_next.esc_cnt  = 2'h0;
        state_next.ctmo_cnt = 16'h0000;
        state_next.t_cnt    = 3'h0;
      end
      if (state_reg.cmd_mode && state_reg.ctmo_cnt + 16'h0001 >= state_reg.prm.ctmo) begin
        state_next.cmd_mode = 1'b0;
      end
    end
    // response drain
    if (state_reg.resp_n != 4'h0 && tx_ready_in) begin
      state_next.resp_buf = {state_reg.resp_buf[55:0], 8'h00};
      state_next.resp_n   = state_reg.resp_n - 4'h1;
    end
    // received byte; select level is the one synchronised at its stop bit
    bin_byte = state_reg.sel_s2 && state_reg.prm.bin_en == BIN_EN_ON;
    hx = asc_hex(rx_data_in);
    if (rx_valid_in) begin
      state_next.silence = 16'h0000;
      if (bin_byte) begin
        state_next.esc_cnt = 2'h0;
        unique case (state_reg.b_state)
          B_IDLE: begin
            state_next.b_code = rx_data_in;
            state_next.b_time = 16'h0000;
            state_next.b_val  = 16'h0000;
            id = bin_id(rx_data_in[6:0]);
            state_next.b_state = (rx_data_in[BC_QUERY_BIT] || id == ID_SAVE ||
                                  id == ID_EXIT) ? B_RUN : B_LO;
          end
          B_LO: begin
            state_next.b_val[7:0] = rx_data_in;
            state_next.b_state    = B_HI;
          end
          B_HI: begin
            state_next.b_val[15:8] = rx_data_in;
            state_next.b_state     = B_RUN;
          end
          B_RUN: begin
            // a new byte while one is still pending is dropped
          end
        endcase
      end else if (state_reg.cmd_mode) begin
        // text path: letter pair, optional hex digits, carriage return
        if (rx_data_in == CH_CR) begin
          id = txt_id(state_reg.t_pair);
          if (state_reg.t_err || state_reg.t_cnt < 3'h4 || id == ID_BAD) begin
            state_next.resp_buf = MSG_ERR;
            state_next.resp_n   = MSG_ERR_N;
          end else begin
            state_next.ctmo_cnt = 16'h0000;
            state_next.resp_buf = MSG_OK;
            state_next.resp_n   = MSG_OK_N;
            if (id == ID_SAVE) begin
              state_next.save = 1'b1;
            end else if (id == ID_EXIT) begin
              state_next.cmd_mode = 1'b0;
            end else if (state_reg.t_has_val) begin
              state_next.prm = prm_write(state_reg.prm, id, state_reg.t_val);
            end else begin
              rv = prm_read(state_reg.prm, id);
              state_next.resp_buf = {hex_asc(rv[15:12]), hex_asc(rv[11:8]), hex_asc(rv[7:4]),
                                     hex_asc(rv[3:0]), CH_CR, 24'h000000};
              state_next.resp_n   = MSG_VAL_N;
            end
          end
          state_next.resp_bin  = 1'b0;
          state_next.t_cnt     = 3'h0;
          state_next.t_err     = 1'b0;
          state_next.t_has_val = 1'b0;
          state_next.t_val     = 16'h0000;
        end else begin
          if (state_reg.t_cnt != 3'h7) state_next.t_cnt = state_reg.t_cnt + 3'h1;
          unique case (state_reg.t_cnt)
            3'h0: state_next.t_err = (rx_data_in & 8'hdf) != CH_A;
            3'h1: state_next.t_err = state_reg.t_err || (rx_data_in & 8'hdf) != CH_T;
            3'h2: state_next.t_pair[15:8] = rx_data_in & 8'hdf;
            3'h3: state_next.t_pair[7:0]  = rx_data_in & 8'hdf;
            default: begin
              if (rx_data_in != 8'h20) begin
                state_next.t_err     = state_reg.t_err || !hx[4];
                state_next.t_val     = {state_reg.t_val[11:0], hx[3:0]};
                state_next.t_has_val = 1'b1;
              end
            end
          endcase
        end
      end else begin
        // payload passes through in arrival order with any binary command
        state_next.pay_valid = 1'b1;
        state_next.pay_data  = rx_data_in;
        if (rx_data_in == state_reg.prm.esc && state_reg.esc_cnt != 2'h3 &&
            (state_reg.esc_cnt == 2'h0 ? state_reg.silence >= state_reg.prm.gbt
                                       : state_reg.esc_time < ESC_WIN_TICKS)) begin
          state_next.esc_cnt = state_reg.esc_cnt + 2'h1;
          if (state_reg.esc_cnt == 2'h0) state_next.esc_time = 16'h0000;
        end else begin
          state_next.esc_cnt = 2'h0;
        end
      end
    end
    // binary execution waits for a receive gap and a free output
    if (state_reg.b_state == B_RUN && !rf_rx_busy_in && state_reg.resp_n == 4'h0) begin
      id = bin_id(state_reg.b_code[6:0]);
      state_next.b_state = B_IDLE;
      if (state_reg.b_code[BC_QUERY_BIT]) begin
        rv = prm_read(state_reg.prm, id);
        state_next.resp_buf = {rv[7:0], rv[15:8], 48'h000000000000};
        state_next.resp_n   = MSG_BIN_N;
        state_next.resp_bin = 1'b1;
      end else if (id == ID_SAVE) begin
        state_next.save = 1'b1;
      end else if (id == ID_EXIT) begin
        state_next.cmd_mode = 1'b0;
      end else begin
        state_next.prm = prm_write(state_reg.prm, id, state_reg.b_val);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_reg <= state_rst;
    end else begin
      state_reg <= state_next;
    end
  end

  // no reset: this copy stands for storage that outlives a power cycle
  always_ff @(posedge clock_in) begin
    if (state_reg.save && !rst_in) begin
      nv_reg <= state_reg.prm;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign tx_valid_out            = state_reg.resp_n != 4'h0;
  assign tx_data_out             = state_reg.resp_buf[63:56];
  assign cts_out                 = !(state_reg.resp_bin && state_reg.resp_n != 4'h0);
  assign payload_valid_out       = state_reg.pay_valid;
  assign payload_data_out        = state_reg.pay_data;
  assign command_mode_out        = state_reg.cmd_mode;
  assign destination_address_out = state_reg.prm.dest;
  assign binary_enable_cfg_out   = state_reg.prm.bin_en;
  assign interface_rate_out      = state_reg.prm.rate;
  assign escape_character_out    = state_reg.prm.esc;

endmodule // sccm_top

/* File: bench/sccm_chk.sv */
// Purpose: port assertions for the command handler
// Assumes: one clock, synchronous reset
// Notes:   bound into sccm_top below
`timescale 1ns/10ps
module sccm_chk (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        rx_valid_in,
  input wire logic [7:0]  rx_data_in,
  input wire logic        tx_ready_in,
  input wire logic        tx_valid_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        cts_out,
  input wire logic        payload_valid_out,
  input wire logic [7:0]  payload_data_out,
  input wire logic        command_mode_out,
  input wire logic [15:0] destination_address_out,
  input wire logic [7:0]  binary_enable_cfg_out
);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_byte_in;
    rx_valid_in && !command_mode_out && binary_enable_cfg_out != 8'h01;
  endsequence
  sequence s_pass_out;
    payload_valid_out && payload_data_out == $past(rx_data_in);
  endsequence
  sequence s_last_take;
    $past(tx_valid_out && tx_ready_in);
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reset_state_a: assert property (disable iff (1'b0) rst_in |=>
    !tx_valid_out && cts_out && !payload_valid_out && !command_mode_out)
    else $error("outputs not idle in reset");
  payload_pass_a: assert property (s_byte_in |=> s_pass_out)
    else $error("payload byte not forwarded");
  payload_cause_a: assert property (payload_valid_out |-> s_pass_out and $past(rx_valid_in))
    else $error("payload without a received byte");
  text_hidden_a: assert property (rx_valid_in && command_mode_out |=> !payload_valid_out)
    else $error("command byte leaked to payload");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out))
    else $error("response byte not held");
  cts_release_a: assert property ($rose(cts_out) |-> s_last_take)
    else $error("cts rose before last byte taken");
  cts_frame_a: assert property ($fell(cts_out) |-> ##[0:1000] tx_valid_out)
    else $error("cts low without response");
  param_guard_a: assert property ($changed(destination_address_out) |-> $past(rst_in)
    || $past(command_mode_out) || $past(binary_enable_cfg_out) == 8'h01)
    else $error("parameter changed outside command paths");
endmodule // sccm_chk

bind sccm_top sccm_chk i_sccm_chk (
  .clock_in(clock_in), .rst_in(rst_in), .rx_valid_in(rx_valid_in),
  .rx_data_in(rx_data_in), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
  .tx_data_out(tx_data_out), .cts_out(cts_out), .payload_valid_out(payload_valid_out),
  .payload_data_out(payload_data_out), .command_mode_out(command_mode_out),
  .destination_address_out(destination_address_out),
  .binary_enable_cfg_out(binary_enable_cfg_out));

/* File: bench/sccm_host.sv */
// Purpose: host side of the transmit path, takes response bytes
// Assumes: ready may be withheld to stall the device
// Notes:   cts is kept with each byte so framing can be judged later
`timescale 1ns/10ps
module sccm_host (
  input  wire logic       clock_in,
  input  wire logic       stall_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       cts_in,
  output logic            tx_ready_out
);
  logic [8:0] q[$];
  initial tx_ready_out = 1'b0;
  always @(posedge clock_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out) q.push_back({cts_in, tx_data_in});
    tx_ready_out <= !stall_in;
  end
endmodule // sccm_host

/* File: bench/test_sccm_top.sv */
// Purpose: directed bench for the command handler
// Assumes: tick shortened to 20 cycles
// Notes:   text, binary, save, abort and strap paths
`timescale 1ns/10ps
module test_sccm_top;
  import sccm_pkg::*;
  logic        clock_in = 1'b0, rst_in = 1'b1, rx_valid_in = 1'b0, cmd_select_in = 1'b1;
  logic        config_strap_n_in = 1'b1, rf_rx_busy_in = 1'b0, stall = 1'b0;
  logic        tx_ready_in, tx_valid_out, cts_out, payload_valid_out, command_mode_out;
  logic [7:0]  rx_data_in = 8'h00, tx_data_out, payload_data_out, pl_last;
  logic [7:0]  binary_enable_cfg_out, interface_rate_out, escape_character_out;
  logic [15:0] destination_address_out;
  int          n_mismatch = 0, total_checks = 0, pl_n = 0;

  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) if (payload_valid_out === 1'b1) begin
    pl_last <= payload_data_out;
    pl_n <= pl_n + 1;
  end

  sccm_top #(.TICK_CYCLES(20)) i_sccm_top (.clock_in(clock_in), .rst_in(rst_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .cmd_select_in(cmd_select_in),
    .config_strap_n_in(config_strap_n_in), .rf_rx_busy_in(rf_rx_busy_in),
    .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
    .cts_out(cts_out), .payload_valid_out(payload_valid_out),
    .payload_data_out(payload_data_out), .command_mode_out(command_mode_out),
    .destination_address_out(destination_address_out),
    .binary_enable_cfg_out(binary_enable_cfg_out),
    .interface_rate_out(interface_rate_out), .escape_character_out(escape_character_out));
  sccm_host i_host (.clock_in(clock_in), .stall_in(stall), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .cts_in(cts_out), .tx_ready_out(tx_ready_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge clock_in);
    rx_valid_in <= 1'b1;
    rx_data_in <= b;
    @(posedge clock_in);
    rx_valid_in <= 1'b0;
  endtask
  task automatic chars(input string s);
    foreach (s[i]) send(s[i]);
  endtask
  task automatic line(input string s);
    chars(s);
    send(CH_CR);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // response bytes sit in the low n bytes of e, first byte highest
  task automatic rsp(input logic [47:0] e, input int n, input logic c);
    int t;
    t = 0;
    while (i_host.q.size() < n && t < 3000) begin
      @(posedge clock_in);
      t++;
    end
    if (i_host.q.size() < n) begin
      chk(16'h0, 16'h1, "response timeout");
      final_report();
    end
    for (int i = n - 1; i >= 0; i--) chk(16'(i_host.q.pop_front()), {7'h0, c, e[8*i+:8]}, "rsp");
  endtask
  task automatic wait_mode(input logic e, input int n);
    int t;
    t = 0;
    while (command_mode_out !== e && t < n) begin
      @(posedge clock_in);
      t++;
    end
    chk(16'(command_mode_out), 16'(e), "mode");
    if (command_mode_out !== e) final_report();
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    wait_n(3);
    rst_in <= 1'b0;
    wait_n(2);
    chk(destination_address_out, DEF_DEST, "dest default");
    chk(16'(interface_rate_out), 16'(RATE_9600), "rate default");
    chk(16'(escape_character_out), 16'(DEF_ESC), "esc default");
    send(8'h55);
    wait_n(2);
    chk(16'(pl_last), 16'h55, "select ignored");
    $display("defaults done");
    wait_n(260);
    chars("++a+");
    wait_n(300);
    chk(16'(command_mode_out), 16'h0, "broken escape");
    chars("+++");
    wait_mode(1'b1, 600);
    pl_n = 0;
    line("ATDT1F");
    rsp(48'h4f4b0d, 3, 1'b1);
    chk(destination_address_out, 16'h001f, "text write");
    line("ATDT");
    rsp(48'h303031460d, 5, 1'b1);
    line("ATQQ");
    rsp(48'h4552524f520d, 6, 1'b1);
    chk(16'(pl_n), 16'h0, "text hidden");
    // timeout first: once binary is on, select-high bytes no longer reach the text path
    line("ATCT2");
    rsp(48'h4f4b0d, 3, 1'b1);
    line("ATRT1");
    rsp(48'h4f4b0d, 3, 1'b1);
    wait_mode(1'b0, 200);
    $display("text done");
    send(8'h00); send(8'h34); send(8'h12);
    wait_n(4);
    chk(destination_address_out, 16'h1234, "binary write");
    rf_rx_busy_in <= 1'b1;
    stall <= 1'b1;
    send(8'h80);
    wait_n(30);
    chk(16'(tx_valid_out), 16'h0, "deferred");
    rf_rx_busy_in <= 1'b0;
    wait_n(5);
    chk(16'(cts_out), 16'h0, "cts framing");
    stall <= 1'b0;
    rsp(48'h3412, 2, 1'b0);
    send(8'h08);
    wait_n(4);
    send(8'h00); send(8'h55); send(8'h55);
    wait_n(4);
    chk(destination_address_out, 16'h5555, "second write");
    send(8'h13); send(8'h2d); send(8'h00);
    wait_n(4);
    chk(16'(escape_character_out), 16'h002d, "binary esc");
    send(8'h15); send(8'h05); send(8'h00);
    wait_n(4);
    chk(16'(interface_rate_out), 16'h0005, "binary rate");
    send(8'h00);
    wait_n(150);
    send(8'h80);
    rsp(48'h5555, 2, 1'b0);
    wait_n(10000);
    cmd_select_in <= 1'b0;
    wait_n(3);
    send(8'h66);
    wait_n(2);
    chk(16'(pl_last), 16'h66, "select low payload");
    $display("binary done");
    rst_in <= 1'b1;
    wait_n(3);
    rst_in <= 1'b0;
    wait_n(2);
    chk(destination_address_out, 16'h1234, "saved set");
    chk(16'(binary_enable_cfg_out), 16'(BIN_EN_ON), "saved enable");
    chk(16'(escape_character_out), 16'(DEF_ESC), "unsaved esc");
    chk(16'(interface_rate_out), 16'(RATE_9600), "unsaved rate");
    config_strap_n_in <= 1'b0;
    rst_in <= 1'b1;
    wait_n(3);
    rst_in <= 1'b0;
    wait_n(8);
    chk(16'(command_mode_out), 16'h1, "strap entry");
    $display("reset and strap done");
    final_report();
  end
endmodule // test_sccm_top
